/* File: core/asp_consts.svh */
// Constants of the audio stream packet mapper: codes, offsets, fields.
// Assumes inclusion by bare name from the mapper and the sink model.
`ifndef ASP_CONSTS_SVH
`define ASP_CONSTS_SVH
`define HB1_SAMPLE 8'h02
`define HB2_RSVD 8'h00
`define CODING_LPCM 4'h0
`define RSVD_BIT 1'b0
`define SS_SYM 8'h5c
`define FLAG_BIT 30
`define BUF_DEPTH 3'h4
`define GRP_LAST 3'h4
`define HDR_SPAN 4'h8
`define WPS_LOW 4'h2
`define WPS_HIGH 4'h8
`define OFF_CTRL 4'h0
`define OFF_STAT 4'h4
`define CTRL_EN 0
`define CTRL_LANE 2:1
`define CTRL_CHAN 5:3
`define CTRL_ID 15:8
`define CTRL_RST 32'h0000_0000
`endif

/* File: core/asp_pkg.sv */
// Types shared by the audio stream packet mapper and its bench.
// Assumes asp_consts.svh on the include path.
package asp_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SS = 2'b01,
    ST_HDR = 2'b10,
    ST_PAY = 2'b11
  } state_type;
  typedef struct packed {
    logic sample_present_flag;
    logic [7:0][31:0] ch;
  } sample_type;
  typedef struct packed {
    logic active;
    logic [3:0] k;
    logic [3:0][7:0] d;
  } lane_type;
  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_type;
endpackage : asp_pkg

/* File: core/audio_stream_packet_mapper.sv */
// Audio stream packet framer: header, sample flag, lane spreading.
// Assumes one link symbol clock; inputs synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
`include "asp_consts.svh"
module audio_stream_packet_mapper (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Register port
  input wire asp_pkg::reg_req_type reg_req,
  output logic [31:0] reg_rdata,
  // Audio sample feed
  input wire logic smp_valid,
  input wire asp_pkg::sample_type smp,
  output logic smp_ready,
  // Video timing and link access
  input wire logic hblank,
  input wire logic vblank,
  input wire logic frame_start,
  input wire logic link_grant,
  // Descriptor and clock-ratio packet handshakes
  input wire logic desc_done,
  input wire logic ratio_done,
  output logic desc_req,
  output logic ratio_req,
  output logic [7:0] stream_id,
  // Main link lanes
  output asp_pkg::lane_type lane_out
);
  import asp_pkg::*;

  // ************************************************
  // Registers and state
  // ************************************************
  state_type state_r, state_nxt;
  sample_type mem [0:3];
  logic [31:0] ctrl_r, rdata_r;
  logic [1:0] wr_ptr_r, rd_ptr_r;
  logic [2:0] fill_r, fill_nxt, cyc_r;
  logic [3:0] step_r, grp_r;
  logic [15:0] pkt_cnt_r;
  logic ready_r, desc_r, ratio_r;
  lane_type lane_r, lane_nxt;

  // ************************************************
  // Decode of configuration
  // ************************************************
  wire logic en_w = ctrl_r[`CTRL_EN];
  wire logic [2:0] chan_w = ctrl_r[`CTRL_CHAN];
  wire logic [1:0] lg_w = (ctrl_r[`CTRL_LANE] == 2'h0) ? 2'h0 :
                          (ctrl_r[`CTRL_LANE] == 2'h1) ? 2'h1 : 2'h2;
  wire logic wide_w = (chan_w > 3'h1);
  wire logic [3:0] wps_w = wide_w ? `WPS_HIGH : `WPS_LOW;
  wire logic [3:0] lanes_w = 4'(4'h1 << lg_w);
  wire logic [3:0] words_w = (wps_w > lanes_w) ? wps_w : lanes_w;
  wire logic [3:0] grp_last_w = 4'((words_w >> lg_w) - 4'h1);
  wire logic [2:0] need_w = (!wide_w && lg_w == 2'h2) ? 3'h2 : 3'h1;
  wire logic [3:0] hdr_last_w = 4'((`HDR_SPAN >> lg_w) - 4'h1);
  wire logic blank_w = hblank || vblank;
  wire logic start_w = en_w && blank_w && link_grant && fill_r >= need_w;
  wire logic pay_end_w = (cyc_r == `GRP_LAST) && (grp_r == grp_last_w);
  wire logic done_w = (state_r == ST_PAY) && pay_end_w;
  wire logic acc_w = smp_valid && ready_r;
  wire logic [3:0][7:0] hb_w = {`CODING_LPCM, `RSVD_BIT, chan_w,
                                `HB2_RSVD, `HB1_SAMPLE,
                                ctrl_r[`CTRL_ID]};
  wire logic reg_ctrl_w = reg_req.addr == `OFF_CTRL;
  wire logic reg_stat_w = reg_req.addr == `OFF_STAT;
  wire logic [31:0] stat_w = {pkt_cnt_r, 10'h000, ratio_r, desc_r,
                              fill_r, state_r != ST_IDLE};
  wire logic [31:0] rd_mux_w = !reg_req.rd ? 32'h0 : reg_ctrl_w ? ctrl_r :
                               reg_stat_w ? stat_w : 32'h0;

  // Write side stamps the one sample flag into every word
  sample_type stamp_w;
  always_comb begin
    stamp_w = smp;
    for (int c = 0; c < 8; c++) begin
      stamp_w.ch[c][`FLAG_BIT] = smp.sample_present_flag;
    end
  end

  // ************************************************
  // Buffer fill and next state
  // ************************************************
  always_comb begin
    fill_nxt = fill_r + {2'h0, acc_w} - (done_w ? need_w : 3'h0);
  end

  always_comb begin
    case (state_r)
      ST_IDLE: state_nxt = start_w ? ST_SS : ST_IDLE;
      ST_SS: state_nxt = ST_HDR;
      ST_HDR: state_nxt = (step_r == hdr_last_w) ? ST_PAY : ST_HDR;
      ST_PAY: state_nxt = pay_end_w ? ST_IDLE : ST_PAY;
      default: state_nxt = ST_IDLE;
    endcase
  end

  // ************************************************
  // Per-lane byte selection
  // ************************************************
  logic [3:0][7:0] byte_w;
  logic [3:0] k_w;
  generate
    for (genvar l = 0; l < 4; l++) begin : g_lane
      wire logic on_w = 4'(l) < lanes_w;
      wire logic [3:0] w_w = 4'((grp_r << lg_w) + 4'(l));
      wire logic [1:0] slot_w = 2'(rd_ptr_r + (wide_w ? 2'h0 : w_w[2:1]));
      wire logic [2:0] ch_w = wide_w ? w_w[2:0] : {2'h0, w_w[0]};
      wire logic [31:0] word_w = mem[slot_w].ch[ch_w];
      wire logic [7:0] par_w = word_w[7:0] ^ word_w[15:8] ^
                               word_w[23:16] ^ word_w[31:24];
      wire logic [7:0] pay_w = (cyc_r == `GRP_LAST) ? par_w :
                               word_w[8*cyc_r +: 8];
      wire logic [1:0] hi_w = 2'(((step_r >> 1) << lg_w) + 4'(l));
      assign k_w[l] = on_w && state_r == ST_SS;
      assign byte_w[l] = !on_w ? 8'h00 :
                         (state_r == ST_SS) ? `SS_SYM :
                         (state_r == ST_HDR) ? hb_w[hi_w] :
                         (state_r == ST_PAY) ? pay_w : 8'h00;
    end
  endgenerate

  always_comb begin
    lane_nxt.active = state_r != ST_IDLE;
    lane_nxt.k = k_w;
    lane_nxt.d = byte_w;
  end

  // ************************************************
  // Flip-flops
  // ************************************************
  always_ff @(posedge clk) begin
    if (acc_w) begin
      mem[wr_ptr_r] <= stamp_w;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= ST_IDLE;
      step_r <= 4'h0;
      grp_r <= 4'h0;
      cyc_r <= 3'h0;
    end else begin
      state_r <= state_nxt;
      step_r <= (state_r == ST_HDR) ? 4'(step_r + 4'h1) : 4'h0;
      cyc_r <= (state_r != ST_PAY || cyc_r == `GRP_LAST) ? 3'h0 :
               3'(cyc_r + 3'h1);
      grp_r <= (state_r != ST_PAY) ? 4'h0 :
               (cyc_r == `GRP_LAST) ? 4'(grp_r + 4'h1) : grp_r;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr_r <= 2'h0;
      rd_ptr_r <= 2'h0;
      fill_r <= 3'h0;
      ready_r <= 1'b0;
      pkt_cnt_r <= 16'h0000;
    end else begin
      wr_ptr_r <= 2'(wr_ptr_r + {1'b0, acc_w});
      rd_ptr_r <= done_w ? 2'(rd_ptr_r + need_w[1:0]) : rd_ptr_r;
      fill_r <= fill_nxt;
      ready_r <= fill_nxt < `BUF_DEPTH;
      pkt_cnt_r <= done_w ? 16'(pkt_cnt_r + 16'h1) : pkt_cnt_r;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_r <= `CTRL_RST;
      rdata_r <= 32'h0;
      desc_r <= 1'b0;
      ratio_r <= 1'b0;
      lane_r <= '0;
    end else begin
      ctrl_r <= (reg_req.wr && reg_ctrl_w) ? reg_req.wdata : ctrl_r;
      rdata_r <= rd_mux_w;
      desc_r <= (frame_start && en_w) || (desc_r && !desc_done);
      ratio_r <= (frame_start && en_w) || (ratio_r && !ratio_done);
      lane_r <= lane_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign smp_ready = ready_r;
  assign desc_req = desc_r;
  assign ratio_req = ratio_r;
  assign stream_id = ctrl_r[`CTRL_ID];
  assign lane_out = lane_r;

  // ************************************************
  // Assertions
  // ************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  frame_req_a: assert property (
    frame_start && en_w |=> desc_req && ratio_req)
    else $error("descriptor or ratio request missing after frame start");
  hblank_start_a: assert property (
    state_r == ST_IDLE && en_w && hblank && link_grant && fill_r >= need_w
    |=> state_r == ST_SS ##1 lane_out.k[0])
    else $error("packet not started in horizontal blanking");
  start_gate_a: assert property (
    $rose(lane_out.active) |-> $past(link_grant && blank_w, 2) &&
    $past(fill_r, 2) >= $past(need_w, 2))
    else $error("packet started without grant, blanking or data");
  hdr_ident_a: assert property (
    lane_out.k[0] && lg_w == 2'h2 |=> lane_out.d[0] == stream_id &&
    lane_out.d[1] == `HB1_SAMPLE && lane_out.d[2] == `HB2_RSVD)
    else $error("header bytes zero to two wrong");
  hdr_three_a: assert property (
    lane_out.k[0] && lg_w == 2'h2 |=> lane_out.d[3][7:3] == 5'h00 &&
    lane_out.d[3][2:0] == chan_w)
    else $error("header byte three wrong");
  flag_same_a: assert property (
    acc_w |=> mem[$past(wr_ptr_r)].ch[0][`FLAG_BIT] ==
    $past(smp.sample_present_flag) &&
    mem[$past(wr_ptr_r)].ch[7][`FLAG_BIT] ==
    $past(smp.sample_present_flag))
    else $error("sample flag not copied to every word");
  sample_end_a: assert property (
    done_w |=> rd_ptr_r == 2'($past(rd_ptr_r) + $past(need_w[1:0])) &&
    fill_r == 3'($past(fill_r) + $past({2'h0, acc_w}) - $past(need_w)))
    else $error("packet end not on a whole sample");
  parity_grp_a: assert property (
    state_r == ST_PAY && cyc_r == `GRP_LAST |=> lane_out.d[0] ==
    ($past(lane_out.d[0], 1) ^ $past(lane_out.d[0], 2) ^
    $past(lane_out.d[0], 3) ^ $past(lane_out.d[0], 4)))
    else $error("parity byte does not cover four payload bytes");
  whole_group_a: assert property (
    state_r == ST_SS |-> fill_r >= need_w)
    else $error("packet begun with an incomplete sample group");

  four_lane_c: cover property (lane_out.k == 4'hf ##[1:40] done_w);
  one_lane_wide_c: cover property (lg_w == 2'h0 && wide_w && done_w);
  vblank_only_c: cover property (vblank && !hblank && start_w);
  full_buf_c: cover property (fill_r == `BUF_DEPTH);
endmodule : audio_stream_packet_mapper
`default_nettype wire

/* File: verification/asp_sink_model.sv */
// Sink receiver model: gathers lane bytes and decodes each packet.
// Assumes the bench sets the lane count to match the mapper setup.
`timescale 1ns/1ps
`default_nettype none
`include "asp_consts.svh"
module asp_sink_model (
  // Link side
  input wire logic clk,
  input wire asp_pkg::lane_type lane_out,
  input wire logic [2:0] lanes
);
  import asp_pkg::*;
  logic [7:0] q[4][$];
  logic [7:0] hb[4];
  logic [31:0] wd[32];
  logic was_act = 1'b0;
  int nw = 0;
  int bad = 0;
  int pkts = 0;
  task automatic decode();
    int h;
    int spw;
    logic [7:0] x;
    h = 8 / lanes;
    for (int i = 0; i < 4; i++) begin
      hb[i] = q[i % lanes][2 * (i / lanes)];
      if (q[i % lanes][2 * (i / lanes) + 1] !== hb[i]) bad++;
    end
    nw = lanes * ((q[0].size() - h) / 5);
    for (int w = 0; w < nw; w++) begin
      x = 8'h00;
      for (int b = 0; b < 5; b++) begin
        if (b < 4) wd[w][8 * b +: 8] = q[w % lanes][h + 5 * (w / lanes) + b];
        x ^= q[w % lanes][h + 5 * (w / lanes) + b];
      end
      if (x !== 8'h00) bad++;
    end
    spw = (hb[3][2:0] < 3'h2) ? 2 : 8;
    if (nw == 0 || nw % spw != 0) bad++;
  endtask : decode
  always @(posedge clk) begin
    was_act <= lane_out.active;
    if (lane_out.active && lane_out.k != 4'h0) begin
      if (lane_out.k != 4'((1 << lanes) - 1)) bad++;
      if (lane_out.d[0] != `SS_SYM) bad++;
      foreach (q[l]) q[l].delete();
    end else if (lane_out.active) begin
      for (int l = 0; l < 4; l++) begin
        if (l < lanes) q[l].push_back(lane_out.d[l]);
        else if (lane_out.d[l] != 8'h00) bad++;
      end
    end else if (was_act) begin
      decode();
      pkts++;
    end
  end
endmodule : asp_sink_model
`default_nettype wire

/* File: verification/audio_stream_packet_mapper_tb.sv */
// Bench for the audio stream packet mapper: registers, frames, packets.
// Assumes asp_sink_model watching the mapper's lanes.
`timescale 1ns/1ps
`default_nettype none
module audio_stream_packet_mapper_tb;
  import asp_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  reg_req_type reg_req = '0;
  sample_type smp = '0;
  logic smp_valid = 1'b0, hblank = 1'b0, vblank = 1'b0, link_grant = 1'b0;
  logic frame_start = 1'b0, desc_done = 1'b0, ratio_done = 1'b0;
  logic smp_ready, desc_req, ratio_req;
  logic [31:0] reg_rdata;
  logic [7:0] stream_id, id;
  lane_type lane_out;
  logic [2:0] lanes = 3'h4;
  logic [4:0] cf[7] = '{5'h11, 5'h17, 5'h09, 5'h0c, 5'h00, 5'h02, 5'h19};
  int fails = 0;
  int checked = 0;
  int np, ns, t;
  audio_stream_packet_mapper i_dut (.clk(clk), .resetn(resetn),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .smp_valid(smp_valid),
    .smp(smp), .smp_ready(smp_ready), .hblank(hblank), .vblank(vblank),
    .frame_start(frame_start), .link_grant(link_grant),
    .desc_done(desc_done), .ratio_done(ratio_done), .desc_req(desc_req),
    .ratio_req(ratio_req), .stream_id(stream_id), .lane_out(lane_out));
  asp_sink_model i_sink (.clk(clk), .lane_out(lane_out), .lanes(lanes));
  initial forever #2 clk = ~clk;
  task automatic chk(string n, logic [31:0] x, logic [31:0] s);
    checked++;
    if (s !== x) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, x, s);
    end
  endtask : chk
  task automatic wr(logic [3:0] a, logic [31:0] v);
    reg_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    reg_req <= '0;
    @(posedge clk);
  endtask : wr
  task automatic rdc(string n, logic [3:0] a, logic [31:0] x);
    reg_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    reg_req <= '0;
    @(posedge clk);
    chk(n, x, reg_rdata);
  endtask : rdc
  function automatic logic [31:0] word(int s, int c, logic flag);
    word = {8'hc0 ^ 8'(s), 8'(c), 16'h5a3c};
    word[30] = flag;
  endfunction : word
  task automatic push(int s);
    smp.sample_present_flag <= (s == 0);
    for (int c = 0; c < 8; c++) smp.ch[c] <= word(s, c, 1'b1);
    smp_valid <= 1'b1;
    do @(posedge clk); while (smp_ready !== 1'b1);
    smp_valid <= 1'b0;
    @(posedge clk);
  endtask : push
  task automatic close_out();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    close_out();
  end
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rdc("ctrl reset", 4'h0, 32'h0);
    chk("ready after reset", 1, smp_ready);
    wr(4'h4, 32'hffff_ffff);
    rdc("status", 4'h4, 32'h0);
    rdc("unmapped", 4'h8, 32'h0);
    wr(4'h0, 32'h0000_ab15);
    rdc("ctrl", 4'h0, 32'h0000_ab15);
    chk("stream id", 8'hab, stream_id);
    $display("test registers done");
    frame_start <= 1'b1;
    @(posedge clk);
    frame_start <= 1'b0;
    @(posedge clk);
    chk("desc req", 1, desc_req);
    chk("ratio req", 1, ratio_req);
    rdc("status reqs", 4'h4, 32'h30);
    desc_done <= 1'b1;
    @(posedge clk);
    desc_done <= 1'b0;
    repeat (2) @(posedge clk);
    chk("desc clear", 0, desc_req);
    chk("ratio held", 1, ratio_req);
    ratio_done <= 1'b1;
    @(posedge clk);
    ratio_done <= 1'b0;
    repeat (2) @(posedge clk);
    chk("ratio clear", 0, ratio_req);
    $display("test frame requests done");
    for (int i = 0; i < 7; i++) begin
      lanes <= (cf[i][4:3] == 2'h0) ? 3'h1 : (cf[i][4:3] == 2'h1) ? 3'h2 : 3'h4;
      np = (cf[i][2:0] < 3'h2) ? 2 : 8;
      ns = (np == 2 && cf[i][4]) ? 2 : 1;
      id = 8'h30 + 8'(i);
      wr(4'h0, {16'h0, id, 2'b00, cf[i][2:0], cf[i][4:3], 1'b1});
      hblank <= i[0];
      vblank <= !i[0];
      link_grant <= 1'b1;
      for (int s = 0; s < ns - 1; s++) push(s);
      repeat (8) @(posedge clk);
      chk("early start", 0, lane_out.active);
      link_grant <= 1'b0;
      push(ns - 1);
      repeat (8) @(posedge clk);
      chk("start without grant", 0, lane_out.active);
      link_grant <= 1'b1;
      for (t = 0; lane_out.active !== 1'b1 && t < 6; t++) @(posedge clk);
      chk("start", 1, lane_out.active);
      for (t = 0; lane_out.active === 1'b1 && t < 100; t++) @(posedge clk);
      repeat (2) @(posedge clk);
      chk("hb0", id, i_sink.hb[0]);
      chk("stream id", id, stream_id);
      chk("hb1", 8'h02, i_sink.hb[1]);
      chk("hb2", 8'h00, i_sink.hb[2]);
      chk("hb3", {5'h00, cf[i][2:0]}, i_sink.hb[3]);
      chk("words", np * ns, i_sink.nw);
      for (int w = 0; w < np * ns; w++)
        chk("word", word(w / np, w % np, w < np), i_sink.wd[w]);
      $display("test packet %0d done", i);
    end
    link_grant <= 1'b0;
    for (int s = 0; s < 4; s++) push(s);
    chk("ready full", 0, smp_ready);
    link_grant <= 1'b1;
    repeat (40) @(posedge clk);
    chk("ready drained", 1, smp_ready);
    $display("test full buffer done");
    chk("sink errors", 0, i_sink.bad);
    chk("packets", 9, i_sink.pkts);
    rdc("status count", 4'h4, 32'h0009_0000);
    close_out();
  end
endmodule : audio_stream_packet_mapper_tb
`default_nettype wire
